/* File: emu_event_pkg.sv */
// constants, modes and register map shared by both ends of the event pins
// assumes one 100 MHz clock for every module that imports it
package emu_event_pkg;

  // clock and test clock timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TCK_HALF_CYC    = 5;
  // incoming line low pulse: whole test clock rises, hard cap below 10 us
  localparam int PULSE_TCK_RISES = 2;
  localparam int PULSE_MAX_NS    = 10000;
  localparam int PULSE_MAX_CYC   = PULSE_MAX_NS / CLK_PERIOD_NS;

  // controller register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h0C;

  // control fields
  localparam int CTRL_INHIBIT_BIT    = 0;
  localparam int CTRL_RESET_MODE_BIT = 1;
  localparam int CTRL_TMS_BIT        = 2;
  localparam int CTRL_SERIAL_BIT     = 3;
  localparam logic [3:0] CTRL_RESET  = 4'h2;

  // status fields
  localparam int STAT_EVENT_A_BIT = 0;
  localparam int STAT_EVENT_B_BIT = 1;
  localparam int STAT_RETURN_BIT  = 2;
  localparam int STAT_PULSE_BIT   = 3;

  // interrupt fields: falling edge seen on each event input
  localparam logic [1:0] IRQ_RESET = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_OFF, MODE_EVENT, MODE_COUNT} event_mode_e;

endpackage

/* File: emu_event_if.sv */
// shared event pins, board split lines and scan chain between the two ends
// assumes pull-ups on both event lines: an undriven event line reads high
interface emu_event_if;
  // device event pins
  logic [1:0] dev_o;
  logic [1:0] dev_oe;
  logic [1:0] dev_in;
  // board pulse and external pulls onto the incoming line
  logic [1:0] brd_o;
  logic [1:0] brd_oe;
  logic [1:0] line_out;
  // scan chain
  logic       tck;
  logic       tms;
  logic       tdi;
  logic       tdo;
  logic       trst_n;

  logic [1:0] pin_level;

  // low wins on the wired line; contention is not modelled
  assign pin_level = ~((dev_oe & ~dev_o) | (brd_oe & ~brd_o));
  assign dev_in    = pin_level;
  assign line_out  = pin_level;

  modport device (
    output dev_o, dev_oe, tdo,
    input  dev_in, tck, tms, tdi, trst_n
  );
  modport controller (
    output brd_o, brd_oe, tck, tms, tdi, trst_n,
    input  line_out, tdo
  );
endinterface

/* File: event_pulse_gen.sv */
// one cross-board pulse generator for one event line
// assumes line_low already synchronised and tck_rise a one-cycle enable
module event_pulse_gen
  import emu_event_pkg::*;
#(
  parameter int RISES   = PULSE_TCK_RISES,
  parameter int MAX_CYC = PULSE_MAX_CYC
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // timing and line
  input  wire logic tck_rise,
  input  wire logic line_low,
  input  wire logic inhibit,
  // pulse onto the incoming line
  output logic      pulse_low
);
  localparam int RW = $clog2(RISES + 1);
  localparam int CW = $clog2(MAX_CYC + 1);

  logic          armed_reg;
  logic          pulse_reg;
  logic [RW-1:0] rise_reg;
  logic [CW-1:0] cyc_reg;

  wire start     = armed_reg & line_low & ~inhibit & ~pulse_reg;
  wire last_rise = tck_rise & (rise_reg == RW'(RISES - 1));
  // ends one cycle short of the cap so the low time stays strictly under it
  wire cap_hit   = cyc_reg == CW'(MAX_CYC - 2);
  wire done      = pulse_reg & (last_rise | cap_hit | inhibit);

  // re-arm only once the outgoing line is seen high again
  wire armed_next = start ? 1'b0 : (armed_reg | ~line_low);
  wire pulse_next = start | (pulse_reg & ~done);
  wire [RW-1:0] rise_next = start ? '0 :
                            (pulse_reg & tck_rise) ? rise_reg + RW'(1) : rise_reg;
  wire [CW-1:0] cyc_next  = start ? '0 : pulse_reg ? cyc_reg + CW'(1) : cyc_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_reg <= 1'b0;
      pulse_reg <= 1'b0;
      rise_reg  <= '0;
      cyc_reg   <= '0;
    end else begin
      armed_reg <= armed_next;
      pulse_reg <= pulse_next;
      rise_reg  <= rise_next;
      cyc_reg   <= cyc_next;
    end
  end

  assign pulse_low = pulse_reg;
endmodule

/* File: emu_event_device.sv */
// processor end: two event pins, halt on event, scan bypass cell
// assumes mode and event controls come from the processor on aclk
module emu_event_device
  import emu_event_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // pins
  emu_event_if.device      pins,
  // processor controls
  input  wire event_mode_e mode_sel,
  input  wire logic        halt_on_event_en,
  input  wire logic [1:0]  event_req,
  input  wire logic [1:0]  event_release,
  input  wire logic        counter_carry,
  input  wire logic        cpu_halted,
  // halt request to the core
  output logic             halt_req
);
  logic [4:0]  sync1_reg;
  logic [4:0]  sync2_reg;
  event_mode_e mode_reg;
  logic [1:0]  low_reg;
  logic [1:0]  pin_o_reg;
  logic [1:0]  pin_oe_reg;
  logic        halt_reg;
  logic        tck_prev_reg;
  logic        bypass_reg;
  logic        tdo_reg;

  wire [4:0] raw      = {pins.trst_n, pins.tdi, pins.tck, pins.dev_in};
  wire [1:0] pin_seen = sync2_reg[1:0];
  wire       tck_s    = sync2_reg[2];
  wire       tdi_s    = sync2_reg[3];
  wire       trst_s_n = sync2_reg[4];
  wire       tck_rise = tck_s & ~tck_prev_reg;
  wire       tck_fall = ~tck_s & tck_prev_reg;

  // request wins over release in the same cycle
  wire [1:0] low_next = (low_reg & ~event_release) | event_req;

  logic [1:0] pin_o_next;
  logic [1:0] pin_oe_next;
  always_comb begin
    pin_o_next  = 2'b00;
    pin_oe_next = 2'b00;
    unique case (mode_reg)
      MODE_OFF: begin
        pin_oe_next = 2'b00;
      end
      MODE_EVENT: begin
        pin_o_next  = 2'b00;
        pin_oe_next = low_reg;
      end
      MODE_COUNT: begin
        pin_o_next  = {counter_carry, cpu_halted};
        pin_oe_next = 2'b11;
      end
      default: begin
        pin_oe_next = 2'b00;
      end
    endcase
  end

  // in count mode the pins carry counter data, not stop requests
  wire sensed_low = (mode_reg != MODE_COUNT) & ~(&pin_seen);
  wire halt_next  = halt_on_event_en & (halt_reg | sensed_low);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // idle levels: pins pulled high, tdi high, tck and trst_n low
      sync1_reg  <= 5'h0B;
      sync2_reg  <= 5'h0B;
      mode_reg   <= MODE_OFF;
      low_reg    <= 2'b00;
      pin_o_reg  <= 2'b00;
      pin_oe_reg <= 2'b00;
      halt_reg   <= 1'b0;
    end else begin
      sync1_reg  <= raw;
      sync2_reg  <= sync1_reg;
      mode_reg   <= mode_sel;
      low_reg    <= low_next;
      pin_o_reg  <= pin_o_next;
      pin_oe_reg <= pin_oe_next;
      halt_reg   <= halt_next;
    end
  end

  // single bypass cell: capture on test clock rise, launch on fall
  always_ff @(posedge aclk) begin
    if (!aresetn || !trst_s_n) begin
      tck_prev_reg <= 1'b0;
      bypass_reg   <= 1'b0;
      tdo_reg      <= 1'b0;
    end else begin
      tck_prev_reg <= tck_s;
      if (tck_rise) begin
        bypass_reg <= tdi_s;
      end
      if (tck_fall) begin
        tdo_reg <= bypass_reg;
      end
    end
  end

  assign pins.dev_o  = pin_o_reg;
  assign pins.dev_oe = pin_oe_reg;
  assign pins.tdo    = tdo_reg;
  assign halt_req    = halt_reg;
endmodule

/* File: emu_event_controller.sv */
// board logic and test bus controller end, with an AXI4-Lite register slave
// assumes a single aclk; tck is made here by a divider and driven out
//
// The register addresses and the AXI4-Lite register port were decided locally.
module emu_event_controller
  import emu_event_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // register bus write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // register bus write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // register bus write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // register bus read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // external source such as an analyser
  input  wire logic [1:0]  ext_pull_req,
  // interrupt
  output logic             irq,
  // lines and scan chain
  emu_event_if.controller  link
);
  logic [2:0]  sync1_reg;
  logic [2:0]  sync2_reg;
  logic [1:0]  event_prev_reg;
  logic [3:0]  ctrl_reg;
  logic [1:0]  stat_reg;
  logic [1:0]  mask_reg;
  logic        irq_reg;
  logic [1:0]  brd_oe_reg;
  logic [$clog2(TCK_HALF_CYC)-1:0] div_reg;
  logic        tck_reg;
  logic        tms_reg;
  logic        tdi_reg;
  logic        trst_n_reg;
  // bus state
  logic        awready_reg;
  logic        wready_reg;
  logic        aw_full_reg;
  logic        w_full_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic        wstrb0_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  // one-hot register select, shared by the read and write paths
  function automatic logic [3:0] reg_sel(input logic [31:0] a);
    reg_sel = {a == {24'h00_0000, OFS_IRQ_MASK},
               a == {24'h00_0000, OFS_IRQ_STAT},
               a == {24'h00_0000, OFS_STATUS},
               a == {24'h00_0000, OFS_CTRL}};
  endfunction

  // synchronised pins: event inputs a and b, scan return
  wire [2:0] raw          = {link.tdo, link.line_out};
  wire [1:0] event_in     = sync2_reg[1:0];
  wire       controller_event_in_a = event_in[0];
  wire       controller_event_in_b = event_in[1];
  wire       controller_scan_return = sync2_reg[2];
  wire       ext_count_inhibit = ctrl_reg[CTRL_INHIBIT_BIT];
  wire       controller_reset_mode_out = ctrl_reg[CTRL_RESET_MODE_BIT];

  // test clock divider, enables one cycle ahead of each edge
  wire div_end  = div_reg == ($bits(div_reg))'(TCK_HALF_CYC - 1);
  wire tck_rise = div_end & ~tck_reg;
  wire tck_fall = div_end & tck_reg;
  wire [$bits(div_reg)-1:0] div_next = div_end ? '0 : div_reg + ($bits(div_reg))'(1);

  // cross-board pulse per line, counted in test clock rises
  logic [1:0] pulse_low;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pulse
      event_pulse_gen u_pulse (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .tck_rise  (tck_rise),
        .line_low  (~event_in[gi]),
        .inhibit   (ext_count_inhibit),
        .pulse_low (pulse_low[gi])
      );
    end
  endgenerate

  // analyser pulls are open-collector and held off while counting
  wire [1:0] ext_pull   = ext_pull_req & {2{~ext_count_inhibit}};
  wire [1:0] brd_oe_next = ext_count_inhibit ? 2'b00 : (pulse_low | ext_pull);

  // write path: address and data taken in either order
  wire aw_take  = s_axi_awvalid & awready_reg;
  wire w_take   = s_axi_wvalid & wready_reg;
  wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire aw_full_next = do_write ? 1'b0 : (aw_full_reg | aw_take);
  wire w_full_next  = do_write ? 1'b0 : (w_full_reg | w_take);
  wire bvalid_next  = do_write | (bvalid_reg & ~s_axi_bready);
  wire [3:0] wsel   = reg_sel(awaddr_reg);
  wire       wr_ok  = do_write & wstrb0_reg;
  wire [1:0] bresp_next = do_write ? ((|wsel) ? RESP_OKAY : RESP_SLVERR) : bresp_reg;

  wire [3:0] ctrl_next = (wr_ok & wsel[0]) ? wdata_reg[3:0] : ctrl_reg;
  wire [1:0] mask_next = (wr_ok & wsel[3]) ? wdata_reg[1:0] : mask_reg;
  // falling event input sets a sticky bit; a new event beats the clear
  wire [1:0] event_fell = event_prev_reg & ~event_in;
  wire [1:0] stat_clr   = (wr_ok & wsel[2]) ? wdata_reg[1:0] : 2'b00;
  wire [1:0] stat_next  = (stat_reg & ~stat_clr) | event_fell;
  wire       irq_next   = |(stat_next & mask_next);

  // read path
  wire ar_take = s_axi_arvalid & arready_reg;
  wire rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);
  wire [3:0] rsel = reg_sel(s_axi_araddr);
  wire [7:0] status_val = {3'h0, |brd_oe_reg, 1'b0, controller_scan_return,
                           controller_event_in_b, controller_event_in_a};
  wire [31:0] rd_val = rsel[0] ? {28'h000_0000, ctrl_reg} :
                       rsel[1] ? {24'h00_0000, status_val} :
                       rsel[2] ? {30'h0000_0000, stat_reg} :
                       rsel[3] ? {30'h0000_0000, mask_reg} : 32'h0000_0000;
  wire [31:0] rdata_next = ar_take ? rd_val : rdata_reg;
  wire [1:0]  rresp_next = ar_take ? ((|rsel) ? RESP_OKAY : RESP_SLVERR) : rresp_reg;

  // scan outputs launched on the falling test clock edge
  wire tms_next = tck_fall ? ctrl_reg[CTRL_TMS_BIT] : tms_reg;
  wire tdi_next = tck_fall ? ctrl_reg[CTRL_SERIAL_BIT] : tdi_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg      <= 3'h7;
      sync2_reg      <= 3'h7;
      event_prev_reg <= 2'b11;
      ctrl_reg       <= CTRL_RESET;
      stat_reg       <= IRQ_RESET;
      mask_reg       <= IRQ_RESET;
      irq_reg        <= 1'b0;
      brd_oe_reg     <= 2'b00;
      div_reg        <= '0;
      tck_reg        <= 1'b0;
      tms_reg        <= 1'b1;
      tdi_reg        <= 1'b1;
      trst_n_reg     <= 1'b0;
    end else begin
      sync1_reg      <= raw;
      sync2_reg      <= sync1_reg;
      event_prev_reg <= event_in;
      ctrl_reg       <= ctrl_next;
      stat_reg       <= stat_next;
      mask_reg       <= mask_next;
      irq_reg        <= irq_next;
      brd_oe_reg     <= brd_oe_next;
      div_reg        <= div_next;
      tck_reg        <= tck_reg ^ div_end;
      tms_reg        <= tms_next;
      tdi_reg        <= tdi_next;
      trst_n_reg     <= ~controller_reset_mode_out;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= 32'h0000_0000;
      wdata_reg   <= 32'h0000_0000;
      wstrb0_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else begin
      awready_reg <= ~aw_full_next;
      wready_reg  <= ~w_full_next;
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg  <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign irq           = irq_reg;
  assign link.brd_oe   = brd_oe_reg;
  assign link.brd_o    = 2'b00;
  assign link.tck      = tck_reg;
  assign link.tms      = tms_reg;
  assign link.tdi      = tdi_reg;
  assign link.trst_n   = trst_n_reg;
endmodule

/* File: emu_event_props.sv */
// concurrent checks on the event lines and scan outputs between both ends
// assumes plain copies of the interface signals and the shared aclk
module emu_event_props
  import emu_event_pkg::*;
(
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // event lines
  input wire logic [1:0] dev_o,
  input wire logic [1:0] dev_oe,
  input wire logic [1:0] brd_oe,
  input wire logic [1:0] line_out,
  // scan
  input wire logic       tck,
  input wire logic       tms,
  input wire logic       tdi
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [9:0] hold_reg;
  logic [9:0] hold_next;
  logic       done_reg;
  logic       done_next;
  logic       prev_reg;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // saturates so a stuck pull cannot wrap back under the cap
  assign hold_next = (brd_oe == 2'b00) ? 10'h000 : hold_reg + 10'(hold_reg != 10'h3ff);
  // pulse on line a ended while the line is still low
  assign done_next = ~line_out[0] & ((prev_reg & ~brd_oe[0]) | done_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_reg <= 10'h000;
      done_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      done_reg <= done_next;
      prev_reg <= brd_oe[0];
    end
  end

  a_idle_after_reset: assert property (
    $rose(aresetn) |-> dev_oe == 2'b00 ##1 dev_oe == 2'b00)
    else $error("event pins driven right after reset");
  a_pins_only_pull: assert property (
    dev_oe != 2'b11 |-> (dev_o & dev_oe) == 2'b00)
    else $error("event pin driven high outside count mode");
  a_pulse_min_a: assert property ($rose(brd_oe[0]) |-> brd_oe[0] [*8] ##1 brd_oe[0] [*3])
    else $error("line a pulse too short");
  a_pulse_min_b: assert property ($rose(brd_oe[1]) |=> brd_oe[1] [*8] ##1 brd_oe[1] [*2])
    else $error("line b pulse too short");
  a_pulse_under_cap: assert property (int'(hold_reg) < PULSE_MAX_CYC - 1)
    else $error("incoming line held low too long");
  a_no_retrigger: assert property (done_reg |-> !brd_oe[0])
    else $error("pulse retriggered before line went high");
  a_tck_half_period: assert property ($rose(tck) |-> tck [*5] ##1 !tck)
    else $error("test clock high time wrong");
  a_scan_shift_low: assert property (
    $changed(tdi) || $changed(tms) |-> !tck)
    else $error("scan outputs changed while test clock high");

  c_pulse: cover property ($rose(brd_oe[0]));
  c_count: cover property (dev_oe == 2'b11 && dev_o[1]);
  c_held: cover property (done_reg);
endmodule

/* File: testbench.sv */
// self-checking bench: device and controller joined by the event interface
// assumes both ends on one 100 MHz aclk; software talks over AXI4-Lite
module testbench
  import emu_event_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        aclk;
  logic        aresetn;
  logic [31:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [31:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [1:0]  ext_pull;
  logic        irq;
  event_mode_e mode_sel;
  logic        halt_en;
  logic [1:0]  ev_req;
  logic [1:0]  ev_rel;
  logic        carry;
  logic        halted;
  logic        halt_req;
  int          error_cnt;
  int          n_checks;
  int          i;
  int          n;

  emu_event_if link_if ();

  emu_event_device emu_event_device_i (.aclk(aclk), .aresetn(aresetn), .pins(link_if.device),
    .mode_sel(mode_sel), .halt_on_event_en(halt_en), .event_req(ev_req),
    .event_release(ev_rel), .counter_carry(carry), .cpu_halted(halted), .halt_req(halt_req));

  emu_event_controller emu_event_controller_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_pull_req(ext_pull), .irq(irq), .link(link_if.controller));

  emu_event_props emu_event_props_i (.aclk(aclk), .aresetn(aresetn), .dev_o(link_if.dev_o),
    .dev_oe(link_if.dev_oe), .brd_oe(link_if.brd_oe), .line_out(link_if.line_out),
    .tck(link_if.tck), .tms(link_if.tms), .tdi(link_if.tdi));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // a wait that ran out ends the run
  task automatic tmo(input logic c);
    chk(32'(c), 32'h0000_0001);
    if (c !== 1'b1) test_done();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    logic       ok;
    ok = 1'b0;
    awaddr <= 32'(a);
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 40 && !ok; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        ok = 1'b1;
      end
    end
    chk(32'(r), 32'(er));
    tmo(ok);
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
                        input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] d;
    logic [1:0]  r;
    logic        ok;
    ok = 1'b0;
    araddr <= 32'(a);
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 40 && !ok; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        ok = 1'b1;
      end
    end
    chk(d & m, e);
    chk(32'(r), 32'(er));
    tmo(ok);
    @(posedge aclk);
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 32'h0000_0000;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    araddr = 32'h0000_0000;
    {ext_pull, ev_req, ev_rel} = 6'h00;
    mode_sel = MODE_OFF;
    {halt_en, carry, halted} = 3'h0;
    error_cnt = 0;
    n_checks = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(OFS_CTRL, 32'(CTRL_RESET), RESP_OKAY);
    chk(32'(link_if.trst_n), 32'h0000_0000);
    axi_rd(8'h10, 32'h0000_0000, RESP_SLVERR);
    axi_wr(8'h10, 32'h0000_0001, RESP_SLVERR);
    // no low byte lane: answered, but nothing lands
    wstrb <= 4'hE;
    axi_wr(OFS_IRQ_MASK, 32'h0000_0003, RESP_OKAY);
    wstrb <= 4'hF;
    axi_rd(OFS_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
    // scan chain: serial out through the device bypass and back
    for (int b = 1; b >= 0; b--) begin
      axi_wr(OFS_CTRL, (32'(b) << CTRL_SERIAL_BIT) | (32'(b) << CTRL_TMS_BIT), RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(32'(link_if.trst_n), 32'h0000_0001);
      for (i = 0; i < 100 && link_if.tdo !== 1'(b); i++) @(posedge aclk);
      tmo(link_if.tdo === 1'(b));
      chk(32'(link_if.tms), 32'(b));
      repeat (4) @(posedge aclk);
      axi_rd(OFS_STATUS, 32'(b) << STAT_RETURN_BIT, RESP_OKAY, 32'h0000_0004);
    end
    ev_req <= 2'b11;
    repeat (4) @(posedge aclk);
    chk(32'(link_if.dev_oe), 32'h0000_0000);
    ev_req <= 2'b00;
    ev_rel <= 2'b11;
    @(posedge aclk);
    ev_rel <= 2'b00;
    // event signalling with halt, board pulse and interrupt on line a
    axi_wr(OFS_IRQ_MASK, 32'h0000_0001, RESP_OKAY);
    mode_sel <= MODE_EVENT;
    halt_en <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'(link_if.dev_oe), 32'h0000_0000);
    ev_req <= 2'b01;
    @(posedge aclk);
    ev_req <= 2'b00;
    repeat (2) @(posedge aclk);
    chk(32'({link_if.dev_oe, link_if.dev_o}), 32'h0000_0004);
    for (i = 0; i < 20 && halt_req !== 1'b1; i++) @(posedge aclk);
    tmo(halt_req === 1'b1);
    for (i = 0; i < 20 && link_if.brd_oe[0] !== 1'b1; i++) @(posedge aclk);
    tmo(link_if.brd_oe[0] === 1'b1);
    for (n = 0; n < 1100 && link_if.brd_oe[0] === 1'b1; n++) @(posedge aclk);
    tmo(n > 2 * TCK_HALF_CYC && n < PULSE_MAX_CYC);
    chk(32'(irq), 32'h0000_0001);
    axi_rd(OFS_STATUS, 32'h0000_0002, RESP_OKAY, 32'h0000_0003);
    repeat (20) @(posedge aclk);
    chk(32'(link_if.brd_oe), 32'h0000_0000);
    ev_rel <= 2'b01;
    @(posedge aclk);
    ev_rel <= 2'b00;
    for (i = 0; i < 20 && link_if.line_out[0] !== 1'b1; i++) @(posedge aclk);
    tmo(link_if.line_out[0] === 1'b1);
    halt_en <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'(halt_req), 32'h0000_0000);
    axi_wr(OFS_IRQ_STAT, 32'h0000_0001, RESP_OKAY);
    axi_rd(OFS_IRQ_STAT, 32'h0000_0000, RESP_OKAY);
    chk(32'(irq), 32'h0000_0000);
    // analyser pull on line b, its interrupt masked
    ext_pull <= 2'b10;
    for (i = 0; i < 10 && link_if.line_out !== 2'b01; i++) @(posedge aclk);
    tmo(link_if.line_out === 2'b01);
    repeat (20) @(posedge aclk);
    axi_rd(OFS_STATUS, 32'h0000_0011, RESP_OKAY, 32'h0000_0013);
    ext_pull <= 2'b00;
    for (i = 0; i < 1100 && link_if.line_out[1] !== 1'b1; i++) @(posedge aclk);
    tmo(link_if.line_out[1] === 1'b1);
    axi_rd(OFS_IRQ_STAT, 32'h0000_0002, RESP_OKAY);
    chk(32'(irq), 32'h0000_0000);
    axi_wr(OFS_IRQ_MASK, 32'h0000_0003, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0000_0001);
    axi_wr(OFS_IRQ_STAT, 32'h0000_0002, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0000_0000);
    // external count with the board logic inhibited
    axi_wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
    carry <= 1'b1;
    mode_sel <= MODE_COUNT;
    halt_en <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'({link_if.dev_oe, link_if.dev_o}), 32'h0000_000e);
    ext_pull <= 2'b11;
    repeat (30) @(posedge aclk);
    chk(32'(link_if.brd_oe), 32'h0000_0000);
    chk(32'(halt_req), 32'h0000_0000);
    carry <= 1'b0;
    halted <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'(link_if.line_out), 32'h0000_0001);
    ext_pull <= 2'b00;
    mode_sel <= MODE_OFF;
    halt_en <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(32'(link_if.dev_oe), 32'h0000_0000);
    test_done();
  end
endmodule
